/* File: logic/lvdx_pkg.sv */
// Package with register map, field positions and reset values of the low-voltage detector.
package lvdx_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] LVDX_CTRL_OFF = 12'h000;
    localparam logic [11:0] LVDX_MASK_OFF = 12'h004;
    localparam logic [11:0] LVDX_STAT_OFF = 12'h008;
    // ------------------------------------------------------------------
    // Control, mask and status register fields and reset values
    // ------------------------------------------------------------------
    localparam int LVDX_FLAG_BIT = 0;
    localparam int LVDX_RSEL_BIT = 1;
    localparam int LVDX_SSEL_BIT = 2;
    localparam int LVDX_ON_BIT   = 7;
    localparam int LVDX_MASK_BIT     = 0;
    localparam int LVDX_STAT_EXT_BIT = 0;
    localparam int LVDX_STAT_VDD_BIT = 1;
    localparam logic [7:0]  LVDX_CTRL_RST = 8'h00;
    localparam logic        LVDX_MASK_RST = 1'b1;
    // ------------------------------------------------------------------
    // Synchroniser depth
    // ------------------------------------------------------------------
    localparam int LVDX_SYNC_STAGES = 2;
endpackage : lvdx_pkg

/* File: logic/lvdx_sync.sv */
// Two-stage synchroniser for the asynchronous comparator output.
`timescale 1ns/1ns
`default_nettype none
module lvdx_sync
    import lvdx_pkg::*;
(
    input  wire logic pclk,    // System clock.
    input  wire logic presetn, // Asynchronous reset, active low.
    input  wire logic async_i, // Asynchronous level.
    output logic      sync_o   // Synchronised level.
);
    logic [LVDX_SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[LVDX_SYNC_STAGES-2:0], async_i};
        end
    end

    assign sync_o = stage_q[LVDX_SYNC_STAGES-1];
endmodule : lvdx_sync
`default_nettype wire

/* File: logic/lvdx_ctrl.sv */
// Control logic of the external low-voltage detector with APB register access.
//
// Overview of operation
// RQ1 - Software masks interrupt before enabling detection.
// RQ2 - Source select bit picks external input.
// RQ3 - Detector works only while enable bit set.
// RQ4 - Software waits settling times before trusting result.
// RQ5 - Bit 0 reports input at or above level.
// RQ6 - Reset select turns detection into reset.
// RQ7 - No reset if level already fine.
// RQ8 - Interrupt is not delayed by settling.
// RQ9 - Software stops: reset select first, then enable.
// RQ10 - Comparator output synchronised by two flip-flops.
`timescale 1ns/1ns
`default_nettype none
module lvdx_ctrl
    import lvdx_pkg::*;
(
    input  wire logic        pclk,          // System clock, 50 MHz.
    input  wire logic        presetn,       // Asynchronous reset, active low.
    input  wire logic        psel,          // APB select.
    input  wire logic        penable,       // APB access phase.
    input  wire logic        pwrite,        // APB write.
    input  wire logic [11:0] paddr,         // APB byte address.
    input  wire logic [31:0] pwdata,        // APB write data.
    output logic      [31:0] prdata,        // APB read data.
    output logic             pready,        // APB ready.
    output logic             pslverr,       // APB error on unmapped address.
    input  wire logic        cmp_ext_above, // Comparator: external input at or above level.
    input  wire logic        cmp_vdd_above, // Comparator: supply at or above level.
    output logic             lowv_irq,      // Interrupt request pulse.
    output logic             lowv_reset,    // Internal reset request, level.
    output logic             lowv_src_ext   // Comparator source select to analog.
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic ext_s;
    logic vdd_s;

    lvdx_sync u_sync_ext (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i (cmp_ext_above),
        .sync_o  (ext_s)
    ); // [RQ10]

    lvdx_sync u_sync_vdd (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i (cmp_vdd_above),
        .sync_o  (vdd_s)
    ); // [RQ10]

    // ------------------------------------------------------------------
    // Local functions
    // ------------------------------------------------------------------
    // One compare per mapped word; anything else falls through to an error.
    function automatic logic lvdx_hit(
        input logic [11:0] addr,
        input logic [11:0] off
    );
        return (addr == off);
    endfunction : lvdx_hit

    // Places one field bit at its position in an otherwise empty read word.
    function automatic logic [31:0] lvdx_place(
        input int   pos,
        input logic val
    );
        logic [31:0] word;
        word      = 32'h0000_0000;
        word[pos] = val;
        return word;
    endfunction : lvdx_place

    // ------------------------------------------------------------------
    // State and next values
    // ------------------------------------------------------------------
    logic        on_q;
    logic        on_d;
    logic        ssel_q;
    logic        ssel_d;
    logic        rsel_q;
    logic        rsel_d;
    logic        mask_q;
    logic        mask_d;
    logic        flag_q;
    logic        flag_d;
    logic        low_event_q;
    logic        low_event_d;
    logic        irq_d;
    logic        reset_d;
    logic        src_ext_d;
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        setup;
    logic        acc;
    logic        wr;
    logic        hit_ctrl;
    logic        hit_mask;
    logic        hit_stat;
    logic        mapped;
    logic        wr_ctrl;
    logic        wr_mask;

    assign setup    = psel & ~penable;
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign hit_ctrl = lvdx_hit(paddr, LVDX_CTRL_OFF);
    assign hit_mask = lvdx_hit(paddr, LVDX_MASK_OFF);
    assign hit_stat = lvdx_hit(paddr, LVDX_STAT_OFF);
    assign mapped   = hit_ctrl | hit_mask | hit_stat;
    assign wr_ctrl  = wr & hit_ctrl;
    assign wr_mask  = wr & hit_mask;

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    assign on_d   = wr_ctrl ? pwdata[LVDX_ON_BIT]   : on_q;   // [RQ3]
    assign ssel_d = wr_ctrl ? pwdata[LVDX_SSEL_BIT] : ssel_q; // [RQ2]
    assign rsel_d = wr_ctrl ? pwdata[LVDX_RSEL_BIT] : rsel_q; // [RQ6]
    assign mask_d = wr_mask ? pwdata[LVDX_MASK_BIT] : mask_q; // [RQ1]

    // ------------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------------
    logic above_sel;
    logic above_now;
    logic low_det;
    logic low_edge;

    assign above_sel   = ssel_q ? ext_s : vdd_s;       // [RQ2]
    assign above_now   = on_q & above_sel;             // [RQ3]
    assign low_det     = on_q & ~above_sel;            // [RQ3]
    assign low_edge    = low_det & ~low_event_q;
    assign flag_d      = above_now;                    // [RQ5]
    assign low_event_d = low_det;
    // The reset follows the select written in this cycle, so a zero write ends it at once.
    // With the level fine, selecting reset mode fires nothing.
    assign reset_d     = low_det & rsel_d;             // [RQ6] [RQ7]
    // No settling gate: a low level right after enable interrupts at once.
    assign irq_d       = low_edge & ~rsel_q & ~mask_q; // [RQ8] [RQ6]
    assign src_ext_d   = ssel_q;                       // [RQ2]

    // ------------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------------
    logic [31:0] ctrl_rd;
    logic [31:0] mask_rd;
    logic [31:0] stat_rd;
    logic [31:0] rd_sel;

    assign ctrl_rd   = lvdx_place(LVDX_ON_BIT, on_q)
                     | lvdx_place(LVDX_SSEL_BIT, ssel_q)
                     | lvdx_place(LVDX_RSEL_BIT, rsel_q)
                     | lvdx_place(LVDX_FLAG_BIT, flag_q);   // [RQ5]
    assign mask_rd   = lvdx_place(LVDX_MASK_BIT, mask_q);
    assign stat_rd   = lvdx_place(LVDX_STAT_VDD_BIT, vdd_s)
                     | lvdx_place(LVDX_STAT_EXT_BIT, ext_s);
    assign rd_sel    = hit_ctrl ? ctrl_rd :
                       hit_mask ? mask_rd :
                       hit_stat ? stat_rd : 32'h0000_0000;
    // Read data is captured in the setup cycle, so it stands through the access phase.
    assign prdata_d  = (setup & ~pwrite) ? rd_sel : prdata;
    assign pready_d  = setup;
    assign pslverr_d = setup & ~mapped;

    // ------------------------------------------------------------------
    // Control and mask registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q   <= LVDX_CTRL_RST[LVDX_ON_BIT];
            ssel_q <= LVDX_CTRL_RST[LVDX_SSEL_BIT];
            rsel_q <= LVDX_CTRL_RST[LVDX_RSEL_BIT];
        end else begin
            on_q   <= on_d;
            ssel_q <= ssel_d;
            rsel_q <= rsel_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= LVDX_MASK_RST;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Detection state
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q      <= 1'b0;
            low_event_q <= 1'b0;
        end else begin
            flag_q      <= flag_d;
            low_event_q <= low_event_d;
        end
    end

    // ------------------------------------------------------------------
    // Event outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowv_irq     <= 1'b0;
            lowv_reset   <= 1'b0;
            lowv_src_ext <= 1'b0;
        end else begin
            lowv_irq     <= irq_d;
            lowv_reset   <= reset_d;
            lowv_src_ext <= src_ext_d;
        end
    end

    // ------------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end
endmodule : lvdx_ctrl
`default_nettype wire

/* File: testbench/lvdx_ctrl_sva.sv */
// Assertions on the ports of the low-voltage detector control block.
`timescale 1ns/1ns
`default_nettype none
module lvdx_ctrl_chk (
    input wire logic        pclk,          // System clock.
    input wire logic        presetn,       // Reset, active low.
    input wire logic        psel,          // Bus select.
    input wire logic        penable,       // Bus access phase.
    input wire logic        pwrite,        // Bus write.
    input wire logic        pready,        // Bus ready.
    input wire logic        pslverr,       // Bus error.
    input wire logic [11:0] paddr,         // Address.
    input wire logic [31:0] prdata,        // Read data.
    input wire logic        cmp_ext_above, // External comparator.
    input wire logic        cmp_vdd_above, // Supply comparator.
    input wire logic        lowv_irq,      // Interrupt pulse.
    input wire logic        lowv_reset,    // Reset request.
    input wire logic        lowv_src_ext   // Source select.
);
    wire logic sel    = lowv_src_ext ? cmp_ext_above : cmp_vdd_above;
    wire logic wr_acc = psel && penable && pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // The comparator reaches the event outputs three edges late through the synchroniser.
    sequence s_low_seen;
        lowv_src_ext ? !$past(cmp_ext_above, 3) : !$past(cmp_vdd_above, 3);
    endsequence
    property p_src_follows_write;
        $changed(lowv_src_ext) |-> $past(wr_acc) || $past(wr_acc, 2);
    endproperty
    setup_ready_a: assert property (s_setup |=> pready) else $error("no ready after setup");
    unmapped_err_a: assert property (pready && paddr > 12'h008 |-> pslverr)
        else $error("no error on unmapped address");
    err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("error read not zero");
    irq_pulse_a: assert property (lowv_irq |=> !lowv_irq) else $error("irq too long");
    irq_cause_a: assert property (lowv_irq |-> s_low_seen ##0 !lowv_reset)
        else $error("irq without low level");
    reset_rise_a: assert property ($rose(lowv_reset) |-> s_low_seen)
        else $error("reset without low level");
    reset_fall_a: assert property (sel [*4] |-> !lowv_reset) else $error("reset high");
    src_change_a: assert property (p_src_follows_write) else $error("source moved");
endmodule : lvdx_ctrl_chk
bind lvdx_ctrl lvdx_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .prdata(prdata), .cmp_ext_above(cmp_ext_above), .cmp_vdd_above(cmp_vdd_above),
    .lowv_irq(lowv_irq), .lowv_reset(lowv_reset), .lowv_src_ext(lowv_src_ext));
`default_nettype wire

/* File: testbench/lvdx_ana.sv */
// Behavioural comparators on the external input and the supply.
`timescale 1ns/1ns
`default_nettype none
module lvdx_ana (
    input  wire logic ext_lvl,       // External level set by the bench.
    input  wire logic vdd_lvl,       // Supply level set by the bench.
    output wire logic cmp_ext_above, // External comparator output.
    output wire logic cmp_vdd_above  // Supply comparator output.
);
    // The skew keeps comparator edges off the clock edge, as a truly async source.
    assign #3 cmp_ext_above = ext_lvl;
    assign #3 cmp_vdd_above = vdd_lvl;
endmodule : lvdx_ana
`default_nettype wire

/* File: testbench/lvdx_ctrl_tb.sv */
// Self-checking bench of the low-voltage detector control block.
`timescale 1ns/1ns
`default_nettype none
module lvdx_ctrl_tb;
    logic pclk, presetn, psel, penable, pwrite, ext_lvl, vdd_lvl;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [7:0] seed;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, lowv_irq, lowv_reset, lowv_src_ext, cmp_ext_above, cmp_vdd_above;
    int n_mismatch, tests_run, cyc, irqs;
    // Stabilisation, minimum pulse width and detection delay: 410 us at 20 ns a cycle.
    localparam int settle_cyc = 410_000 / 20;
    lvdx_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_ext_above(cmp_ext_above), .cmp_vdd_above(cmp_vdd_above),
        .lowv_irq(lowv_irq), .lowv_reset(lowv_reset), .lowv_src_ext(lowv_src_ext));
    lvdx_ana u_ana (.ext_lvl(ext_lvl), .vdd_lvl(vdd_lvl), .cmp_ext_above(cmp_ext_above),
        .cmp_vdd_above(cmp_vdd_above));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value %s exp %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic chk_pin(input string n, input logic x, input logic g);
        chk(n, {31'h0, x}, {31'h0, g});
    endtask : chk_pin
    task automatic end_sim;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // Each transfer notes {read, error, data}; the monitor compares it at pready.
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [33:0] x);
        exp_q.push_back(x);
        seed = lfsr(seed);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {seed, 16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (lowv_irq === 1'b1) irqs <= irqs + 1;
        if (cyc == settle_cyc + 3000) begin
            n_mismatch++;
            end_sim();
        end
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            chk_pin("err", e[32], pslverr);
            if (e[33]) chk("rd", e[31:0], prdata);
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {seed, ext_lvl, vdd_lvl} = {8'h58, 2'b11};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, 12'h000, 0, {2'b10, 32'h0});
        bus(0, 12'h004, 0, {2'b10, 32'h1});
        bus(0, 12'h00C, 0, {2'b11, 32'h0});
        bus(1, 12'h00C, 8'hFF, {2'b01, 32'h0});
        bus(0, 12'h008, 0, {2'b10, 32'h3});
        bus(0, 12'h000, 0, {2'b10, 32'h0});
        $display("register test done");
        bus(1, 12'h004, 1, 34'h0);
        bus(1, 12'h000, 8'h84, 34'h0);
        @(posedge pclk);
        chk_pin("src", 1'b1, lowv_src_ext);
        repeat (settle_cyc) @(posedge pclk);
        bus(0, 12'h000, 0, {2'b10, 32'h85});
        bus(1, 12'h000, 8'h86, 34'h0);
        repeat (4) @(posedge pclk);
        chk_pin("rst", 1'b0, lowv_reset);
        ext_lvl <= 1'b0;
        repeat (5) @(posedge pclk);
        chk_pin("rst", 1'b1, lowv_reset);
        bus(0, 12'h000, 0, {2'b10, 32'h86});
        bus(1, 12'h000, 0, 34'h0);
        @(posedge pclk);
        chk_pin("rst", 1'b0, lowv_reset);
        $display("reset mode test done");
        bus(1, 12'h004, 0, 34'h0);
        bus(1, 12'h000, 8'h84, 34'h0);
        repeat (3) @(posedge pclk);
        chk("irq", 1, irqs);
        bus(1, 12'h000, 8'h80, 34'h0);
        bus(0, 12'h000, 0, {2'b10, 32'h81});
        vdd_lvl <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("irq", 2, irqs);
        $display("irq test done");
        end_sim();
    end
endmodule : lvdx_ctrl_tb
`default_nettype wire
